// ==== hdl/iso_pkg.sv ====
package iso_pkg;
  // Fast-path filter width and core timing (core clock 4 ns)
  localparam int CLK_PERIOD_NS      = 4;
  localparam int GLITCH_NS          = 10;
  localparam int GLITCH_CYC         = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Slow exchange: two 1.2 us half-exchanges (sample, shift) per direction, 1.2 us idle refresh, 5 us watchdog
  localparam int HALF_EXCHANGE_NS   = 1200;
  localparam int HALF_EXCHANGE_CYC  = HALF_EXCHANGE_NS / CLK_PERIOD_NS;
  localparam int REFRESH_NS         = 1200;
  localparam int REFRESH_CYC        = REFRESH_NS / CLK_PERIOD_NS;
  localparam int WATCHDOG_NS        = 5000;
  localparam int WATCHDOG_CYC       = WATCHDOG_NS / CLK_PERIOD_NS;
  localparam int OUT_LATCH_CYC      = 25;
  localparam int SLOW_CHANNELS      = 3;
  // Packet layout: slow bits low, then clock, data and select levels
  localparam int PKT_W              = SLOW_CHANNELS + 3;
  localparam int PKT_CLK_BIT        = SLOW_CHANNELS;
  localparam int PKT_DATA_BIT       = SLOW_CHANNELS + 1;
  localparam int PKT_SEL_BIT        = SLOW_CHANNELS + 2;
  localparam logic [2:0] SLOW_RESET = 3'h0;

  typedef enum logic [1:0] {
    XCH_FWD_SAMPLE = 2'b00,
    XCH_FWD_SHIFT  = 2'b01,
    XCH_REV_SAMPLE = 2'b10,
    XCH_REV_SHIFT  = 2'b11
  } xch_state_t;
endpackage : iso_pkg

// ==== hdl/fast_path.sv ====
`timescale 1ns/1ns
// One fast channel: two-flop capture, optional glitch filter, refresh repair
module fast_path import iso_pkg::*; #(
  parameter bit FILTER    = 1'b1,
  parameter bit IDLE      = 1'b0,
  parameter int FILT_CYC  = GLITCH_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Level in, repair request, level out
  input  wire logic pin_in,
  input  wire logic repair,
  output logic      level_out,
  output logic      level_raw
);
  initial begin
    if (FILT_CYC < 1 || FILT_CYC > 15) $error("fast_path: FILT_CYC out of range");
  end

  logic       sync1_reg;
  logic       sync2_reg;
  logic       out_reg;
  logic [3:0] stable_reg;
  logic [3:0] stable_next;

  wire differs = sync2_reg != out_reg;
  wire settled = stable_reg >= 4'(FILT_CYC - 1);

  assign stable_next = differs ? (settled ? 4'h0 : stable_reg + 4'h1) : 4'h0;
  assign level_out   = out_reg;
  assign level_raw   = sync2_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg  <= IDLE;
      sync2_reg  <= IDLE;
      stable_reg <= 4'h0;
      out_reg    <= IDLE;
    end else begin
      sync1_reg  <= pin_in;
      sync2_reg  <= sync1_reg;
      stable_reg <= stable_next;
      // Unfiltered grade follows every edge; a lost trailing edge is fixed by repair
      if (!FILTER || repair)
        out_reg <= sync2_reg;
      else if (differs && settled)
        out_reg <= sync2_reg;
    end
  end
endmodule : fast_path

// ==== hdl/spi_iso_channel.sv ====
`timescale 1ns/1ns
// Behaviour
// - Noise-immune grade filters clock and both data paths; low-delay grade does not.
// - Low-delay false level after a lost edge is fixed at refresh or next edge.
// - Clock, main data and select go side 1 to 2; subordinate data returns.
// - Fast paths pass levels without syncing to SPI clock; any mode works.
// - Side-1 main data output is always driven, never floats.
// - Select path is glitch filtered in every grade.
// - Each exchange samples all inputs of one side at one instant and ships them.
// - Receiver checks fast levels, drives slow outputs, then direction reverses.
// - All slow outputs of a side update on one clock edge.
// - Free-running clock paces exchange; slow delay about 1.2 to 6 us.
// - Edges within one sample interval appear together at outputs.
// - Sample between two close edges widens gap to one output period.
// - Slow pulses below minimum width may be missed.
// - Slow edges apart by the minimum separation keep their order.
// - Input idle about 1.2 us triggers refresh of current level.
// - No slow traffic for about 5 us forces slow outputs to high impedance.
module spi_iso_channel import iso_pkg::*; #(
  parameter bit LOW_DELAY_GRADE = 1'b0,
  parameter int WATCHDOG_CYCLES = WATCHDOG_CYC,
  parameter int HALF_CYCLES     = HALF_EXCHANGE_CYC,
  parameter int REFRESH_CYCLES  = REFRESH_CYC
) (
  // Core clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Side 1, facing the main controller
  input  wire logic       main_side_clk_in,
  input  wire logic       main_side_data_in,
  input  wire logic       main_side_select_in,
  output logic            main_side_data_out,
  // Side 2, facing the subordinate
  output logic            far_side_clk_out,
  output logic            far_side_data_out,
  output logic            far_side_select_out,
  input  wire logic       far_side_data_in,
  // Slow channels, side 1 to side 2
  input  wire logic [2:0] slow1_in,
  output logic      [2:0] slow2_out,
  output logic      [2:0] slow2_oe,
  // Slow channels, side 2 to side 1
  input  wire logic [2:0] slow2_in,
  output logic      [2:0] slow1_out,
  output logic      [2:0] slow1_oe,
  // Far-side liveness, low when that side is unpowered
  input  wire logic       far_side_alive
);
  initial begin
    if (HALF_CYCLES < 2 || HALF_CYCLES > 65535) $error("spi_iso_channel: HALF_CYCLES out of range");
    if (WATCHDOG_CYCLES <= 2 * HALF_CYCLES || WATCHDOG_CYCLES > 65535)
      $error("spi_iso_channel: WATCHDOG_CYCLES must exceed one full exchange");
    if (REFRESH_CYCLES < 1 || REFRESH_CYCLES > 65535) $error("spi_iso_channel: REFRESH_CYCLES out of range");
  end

  // Two-flop capture of slow inputs and liveness
  logic [2:0] s1_meta_reg, s1_sync_reg, s2_meta_reg, s2_sync_reg;
  logic       alive_meta_reg, alive_sync_reg;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_meta_reg    <= SLOW_RESET;
      s1_sync_reg    <= SLOW_RESET;
      s2_meta_reg    <= SLOW_RESET;
      s2_sync_reg    <= SLOW_RESET;
      alive_meta_reg <= 1'b0;
      alive_sync_reg <= 1'b0;
    end else begin
      s1_meta_reg    <= slow1_in;
      s1_sync_reg    <= s1_meta_reg;
      s2_meta_reg    <= slow2_in;
      s2_sync_reg    <= s2_meta_reg;
      alive_meta_reg <= far_side_alive;
      alive_sync_reg <= alive_meta_reg;
    end
  end

  // Fast channels
  wire clk_lvl, data_lvl, sel_lvl, miso_lvl;
  wire clk_raw, data_raw, sel_raw, miso_raw;
  logic repair_fwd_reg, repair_rev_reg;

  fast_path #(.FILTER(!LOW_DELAY_GRADE)) u_clk (
    .core_clk (core_clk), .rstn (rstn), .pin_in (main_side_clk_in),
    .repair (repair_fwd_reg), .level_out (clk_lvl), .level_raw (clk_raw));
  fast_path #(.FILTER(!LOW_DELAY_GRADE)) u_mosi (
    .core_clk (core_clk), .rstn (rstn), .pin_in (main_side_data_in),
    .repair (repair_fwd_reg), .level_out (data_lvl), .level_raw (data_raw));
  // Select idles high; a low reset level would fake a select pulse right after reset
  fast_path #(.FILTER(1'b1), .IDLE(1'b1)) u_sel (
    .core_clk (core_clk), .rstn (rstn), .pin_in (main_side_select_in),
    .repair (1'b0), .level_out (sel_lvl), .level_raw (sel_raw));
  fast_path #(.FILTER(!LOW_DELAY_GRADE)) u_miso (
    .core_clk (core_clk), .rstn (rstn), .pin_in (far_side_data_in),
    .repair (repair_rev_reg), .level_out (miso_lvl), .level_raw (miso_raw));

  // Exchange sequencer, free-running
  xch_state_t  state_reg, state_next;
  logic [15:0] phase_reg;
  logic [15:0] idle_fwd_reg, idle_rev_reg;
  logic [15:0] dog_reg;
  logic [PKT_W-1:0] pkt_reg;
  logic [PKT_W-1:0] last_fwd_reg, last_rev_reg;

  wire phase_end = phase_reg == 16'(HALF_CYCLES - 1);
  wire sample_now = phase_end && (state_reg == XCH_FWD_SAMPLE || state_reg == XCH_REV_SAMPLE);
  wire deliver    = phase_end && (state_reg == XCH_FWD_SHIFT || state_reg == XCH_REV_SHIFT);
  wire [PKT_W-1:0] fwd_pkt = {sel_raw, data_raw, clk_raw, s1_sync_reg};
  wire [PKT_W-1:0] rev_pkt = {1'b1, miso_raw, 1'b0, s2_sync_reg};
  wire fwd_changed = fwd_pkt != last_fwd_reg;
  wire rev_changed = rev_pkt != last_rev_reg;
  wire fwd_refresh = idle_fwd_reg >= 16'(REFRESH_CYCLES - 1);
  wire rev_refresh = idle_rev_reg >= 16'(REFRESH_CYCLES - 1);
  wire traffic     = deliver && alive_sync_reg;
  wire dog_expired = dog_reg >= 16'(WATCHDOG_CYCLES - 1);

  always_comb begin
    case (state_reg)
      XCH_FWD_SAMPLE: state_next = XCH_FWD_SHIFT;
      XCH_FWD_SHIFT:  state_next = XCH_REV_SAMPLE;
      XCH_REV_SAMPLE: state_next = XCH_REV_SHIFT;
      XCH_REV_SHIFT:  state_next = XCH_FWD_SAMPLE;
      default:        state_next = XCH_FWD_SAMPLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= XCH_FWD_SAMPLE;
      phase_reg <= 16'h0000;
    end else if (phase_end) begin
      state_reg <= state_next;
      phase_reg <= 16'h0000;
    end else begin
      phase_reg <= phase_reg + 16'h0001;
    end
  end

  // All inputs of a side captured in one cycle; outputs of a side move in one cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pkt_reg        <= '0;
      last_fwd_reg   <= '0;
      last_rev_reg   <= '0;
      slow1_out      <= SLOW_RESET;
      slow2_out      <= SLOW_RESET;
      repair_fwd_reg <= 1'b0;
      repair_rev_reg <= 1'b0;
    end else begin
      repair_fwd_reg <= 1'b0;
      repair_rev_reg <= 1'b0;
      if (sample_now)
        pkt_reg <= (state_reg == XCH_FWD_SAMPLE) ? fwd_pkt : rev_pkt;
      if (deliver && alive_sync_reg && state_reg == XCH_FWD_SHIFT) begin
        slow2_out      <= pkt_reg[SLOW_CHANNELS-1:0];
        last_fwd_reg   <= pkt_reg;
        // Static check of fast levels; a mismatch or idle refresh restores the level
        repair_fwd_reg <= (pkt_reg[PKT_CLK_BIT] != clk_lvl) || (pkt_reg[PKT_DATA_BIT] != data_lvl)
                          || fwd_refresh;
      end
      if (deliver && alive_sync_reg && state_reg == XCH_REV_SHIFT) begin
        slow1_out      <= pkt_reg[SLOW_CHANNELS-1:0];
        last_rev_reg   <= pkt_reg;
        repair_rev_reg <= (pkt_reg[PKT_DATA_BIT] != miso_lvl) || rev_refresh;
      end
    end
  end

  // Idle timers for refresh, and receive watchdog
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      idle_fwd_reg <= 16'h0000;
      idle_rev_reg <= 16'h0000;
      dog_reg      <= 16'h0000;
    end else begin
      idle_fwd_reg <= (fwd_changed || (repair_fwd_reg)) ? 16'h0000 :
                      (fwd_refresh ? idle_fwd_reg : idle_fwd_reg + 16'h0001);
      idle_rev_reg <= (rev_changed || (repair_rev_reg)) ? 16'h0000 :
                      (rev_refresh ? idle_rev_reg : idle_rev_reg + 16'h0001);
      if (traffic)
        dog_reg <= 16'h0000;
      else if (!dog_expired)
        dog_reg <= dog_reg + 16'h0001;
    end
  end

  // Output drivers; main data output stays driven even with select high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      main_side_data_out  <= 1'b0;
      far_side_clk_out    <= 1'b0;
      far_side_data_out   <= 1'b0;
      far_side_select_out <= 1'b1;
      slow1_oe            <= 3'h0;
      slow2_oe            <= 3'h0;
    end else begin
      main_side_data_out  <= miso_lvl;
      far_side_clk_out    <= clk_lvl;
      far_side_data_out   <= data_lvl;
      far_side_select_out <= sel_lvl;
      slow1_oe            <= {3{!dog_expired}};
      slow2_oe            <= {3{!dog_expired}};
    end
  end
endmodule : spi_iso_channel

// ==== bench/iso_monitor.sv ====
`timescale 1ns/1ns
module iso_monitor import iso_pkg::*; #(
  parameter int HALF_CYCLES     = HALF_EXCHANGE_CYC,
  parameter int WATCHDOG_CYCLES = WATCHDOG_CYC
) (
  // Clock, reset, liveness
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       far_side_alive,
  // Fast pins
  input wire logic       main_side_clk_in,
  input wire logic       main_side_data_in,
  input wire logic       main_side_select_in,
  input wire logic       main_side_data_out,
  input wire logic       far_side_clk_out,
  input wire logic       far_side_data_out,
  input wire logic       far_side_select_out,
  input wire logic       far_side_data_in,
  // Slow pins
  input wire logic [2:0] slow1_in,
  input wire logic [2:0] slow2_out,
  input wire logic [2:0] slow2_oe,
  input wire logic [2:0] slow2_in,
  input wire logic [2:0] slow1_out,
  input wire logic [2:0] slow1_oe
);
  localparam int SLOW_HI = 5 * HALF_CYCLES + 4;
  localparam int DOG_HI  = WATCHDOG_CYCLES + 2 * HALF_CYCLES + 4;
  logic [1:0] sel_low_cnt;
  logic       sel_long;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // An output fall is only legal once the pin has been low for three samples
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sel_low_cnt <= 2'h0;
      sel_long    <= 1'h0;
    end else begin
      sel_low_cnt <= main_side_select_in ? 2'h0 : sel_low_cnt + {1'h0, sel_low_cnt != 2'h3};
      sel_long    <= !$fell(far_side_select_out) && (sel_long || (!main_side_select_in && sel_low_cnt >= 2'h2));
    end
  end
  clk_follow_a: assert property ($stable(main_side_clk_in) [*8] |-> far_side_clk_out == main_side_clk_in)
    else $error("clock output lost its pin level");
  mosi_follow_a: assert property ($stable(main_side_data_in) [*8] |-> far_side_data_out == main_side_data_in)
    else $error("forward data output lost its pin level");
  sel_follow_a: assert property ($stable(main_side_select_in) [*8] |-> far_side_select_out == main_side_select_in)
    else $error("select output lost its pin level");
  miso_follow_a: assert property ($stable(far_side_data_in) [*8] |-> main_side_data_out == far_side_data_in)
    else $error("return data output lost its pin level");
  sel_glitch_a: assert property ($fell(far_side_select_out) |-> sel_long)
    else $error("short select pulse reached the output");
  slow_together_a: assert property (!$stable(slow2_out) |=> $stable(slow2_out) [*8])
    else $error("slow outputs changed on separate edges");
  slow_delay_a: assert property (disable iff (!rstn || !far_side_alive)
    $changed(slow1_in) ##1 $stable(slow1_in) [*8] |-> ##[0:SLOW_HI] slow2_out == slow1_in)
    else $error("slow forward level late");
  dog_expire_a: assert property ($fell(far_side_alive) |-> ##[1:DOG_HI] (slow1_oe == 3'h0 && slow2_oe == 3'h0))
    else $error("slow drivers not released after silence");
  cover property ($fell(far_side_select_out));
  cover property (!$stable(slow2_out));
  cover property ($fell(far_side_alive));
endmodule : iso_monitor
bind spi_iso_channel iso_monitor #(.HALF_CYCLES(HALF_CYCLES), .WATCHDOG_CYCLES(WATCHDOG_CYCLES)) mon (
  .core_clk, .rstn, .far_side_alive, .main_side_clk_in, .main_side_data_in, .main_side_select_in,
  .main_side_data_out, .far_side_clk_out, .far_side_data_out, .far_side_select_out, .far_side_data_in,
  .slow1_in, .slow2_out, .slow2_oe, .slow2_in, .slow1_out, .slow1_oe);

// ==== bench/spi_sub_model.sv ====
`timescale 1ns/1ns
// Far-side subordinate: samples on the rising clock edge, shifts out on the falling one
module spi_sub_model (
  input  wire logic sclk,
  input  wire logic sel_n,
  input  wire logic mosi,
  output logic      miso
);
  logic [7:0] rx_reg;
  initial begin
    rx_reg = 8'h00;
    miso   = 1'h0;
  end
  always @(posedge sclk) if (!sel_n) rx_reg <= {rx_reg[6:0], mosi};
  always @(negedge sclk) if (!sel_n) miso <= rx_reg[7];
  // Deselected, the line is not held: show the inverse of its last level
  always @(posedge sel_n) miso <= ~miso;
endmodule : spi_sub_model

// ==== bench/tb.sv ====
`timescale 1ns/1ns
module tb;
  localparam int HALF = 8;
  logic       core_clk, rstn, far_side_alive, main_side_clk_in, main_side_data_in, main_side_select_in;
  logic       main_side_data_out, far_side_clk_out, far_side_data_out, far_side_select_out, far_side_data_in;
  logic [2:0] slow1_in, slow2_out, slow2_oe, slow2_in, slow1_out, slow1_oe;
  int         fails, checks_done;
  logic       hold_fast;
  logic       ld_clk_out, ld_data_out, ld_sel_out, ld_main_data_out;
  logic [2:0] ld_slow2_out, ld_slow2_oe, ld_slow1_out, ld_slow1_oe;
  // The low-delay grade must never see sub-10 ns clock or data pulses, so the bench masks them off those two pins
  wire        ld_clk_in  = main_side_clk_in & !hold_fast;
  wire        ld_data_in = main_side_data_in & !hold_fast;
  // Short exchange and watchdog counts keep the run brief
  spi_iso_channel #(.WATCHDOG_CYCLES(40), .HALF_CYCLES(HALF), .REFRESH_CYCLES(HALF)) dut (
    .core_clk, .rstn, .main_side_clk_in, .main_side_data_in, .main_side_select_in, .main_side_data_out,
    .far_side_clk_out, .far_side_data_out, .far_side_select_out, .far_side_data_in, .slow1_in, .slow2_out,
    .slow2_oe, .slow2_in, .slow1_out, .slow1_oe, .far_side_alive);
  spi_sub_model sub (.sclk(far_side_clk_out), .sel_n(far_side_select_out), .mosi(far_side_data_out),
                     .miso(far_side_data_in));
  spi_iso_channel #(.LOW_DELAY_GRADE(1'b1), .WATCHDOG_CYCLES(40), .HALF_CYCLES(HALF),
                    .REFRESH_CYCLES(HALF)) dut_fast (
    .core_clk, .rstn, .main_side_clk_in(ld_clk_in), .main_side_data_in(ld_data_in), .main_side_select_in,
    .main_side_data_out(ld_main_data_out), .far_side_clk_out(ld_clk_out), .far_side_data_out(ld_data_out),
    .far_side_select_out(ld_sel_out), .far_side_data_in, .slow1_in, .slow2_out(ld_slow2_out),
    .slow2_oe(ld_slow2_oe), .slow2_in, .slow1_out(ld_slow1_out), .slow1_oe(ld_slow1_oe), .far_side_alive);
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    checks_done++;
    if (seen !== want) begin
      fails++;
      $display("FAIL at %0t: %s", $time, what);
    end
  endtask : check
  task automatic wrap_up;
    $display("Summary: %0d compares, %0d mismatches", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic glitch_test;
    {hold_fast, main_side_select_in, main_side_data_in, main_side_clk_in} <= 4'hB;
    cyc(2);
    {hold_fast, main_side_select_in, main_side_data_in, main_side_clk_in} <= 4'h4;
    repeat (12) begin
      @(negedge core_clk);
      check({far_side_select_out, far_side_data_out, far_side_clk_out}, 3'h4, "short pulse passed");
      check({ld_sel_out, ld_data_out, ld_clk_out}, 3'h4, "low-delay grade passed a pulse");
    end
    // A clean clock edge: the unfiltered grade shows it two cycles before the filtered one
    @(posedge core_clk);
    main_side_clk_in <= 1'h1;
    cyc(4);
    @(negedge core_clk);
    check({ld_clk_out, far_side_clk_out}, 2'h2, "grades not told apart");
    cyc(4);
    check({ld_clk_out, far_side_clk_out}, 2'h3, "clock edge lost");
    main_side_clk_in <= 1'h0;
    $display("Test glitch done");
  endtask : glitch_test
  // Modes 0 and 3 both sample on the rising edge, so one subordinate model serves both
  task automatic spi_frame(input logic idle, input logic [7:0] tx);
    main_side_clk_in <= idle;
    cyc(8);
    main_side_select_in <= 1'h0;
    cyc(4);
    for (int i = 7; i >= 0; i--) begin
      {main_side_clk_in, main_side_data_in} <= {1'h0, tx[i]};
      cyc(4);
      main_side_clk_in <= 1'h1;
      cyc(4);
    end
    main_side_clk_in <= idle;
    cyc(4);
    main_side_select_in <= 1'h1;
    cyc(20);
    check(sub.rx_reg, tx, "byte at subordinate");
    check(main_side_data_out, far_side_data_in, "return level");
    check(ld_main_data_out, far_side_data_in, "return level, low-delay grade");
    $display("Test frame idle=%0b done", idle);
  endtask : spi_frame
  task automatic slow_test;
    int t0 = -1;
    int t2 = -1;
    slow1_in <= 3'h1;
    cyc(2);
    slow1_in <= 3'h5;
    for (int t = 0; t < 100; t++) begin
      @(negedge core_clk);
      if (t0 < 0 && slow2_out[0] === 1'h1) t0 = t;
      if (t2 < 0 && slow2_out[2] === 1'h1) t2 = t;
    end
    check(t0 >= 0 && t2 >= t0 && t2 - t0 <= 4 * HALF, 1'h1, "slow edge order");
    check(t0 <= 5 * HALF + 4, 1'h1, "slow delay");
    check(slow2_out, 3'h5, "slow forward level");
    check(ld_slow2_out, 3'h5, "slow forward level, low-delay grade");
    slow2_in <= 3'h6;
    cyc(5 * HALF + 8);
    check(slow1_out, 3'h6, "slow reverse level");
    check(ld_slow1_out, 3'h6, "slow reverse level, low-delay grade");
    $display("Test slow done");
  endtask : slow_test
  task automatic dog_test;
    check({slow1_oe, slow2_oe}, 6'h3F, "drivers off while alive");
    check({ld_slow1_oe, ld_slow2_oe}, 6'h3F, "low-delay drivers off while alive");
    far_side_alive <= 1'h0;
    cyc(40 + 2 * HALF + 8);
    check({slow1_oe, slow2_oe}, 6'h00, "drivers still on");
    check({ld_slow1_oe, ld_slow2_oe}, 6'h00, "low-delay drivers still on");
    far_side_alive <= 1'h1;
    cyc(6 * HALF);
    check({slow1_oe, slow2_oe}, 6'h3F, "drivers not back");
    check({ld_slow1_oe, ld_slow2_oe}, 6'h3F, "low-delay drivers not back");
    $display("Test watchdog done");
  endtask : dog_test
  initial begin
    {rstn, far_side_alive, main_side_clk_in, main_side_data_in, main_side_select_in} = 5'h09;
    {hold_fast, slow1_in, slow2_in} = 7'h00;
    fails = 0;
    checks_done = 0;
    cyc(2);
    rstn <= 1'h1;
    cyc(20);
    glitch_test;
    spi_frame(1'h0, 8'h3C);
    spi_frame(1'h1, 8'hA6);
    slow_test;
    dog_test;
    wrap_up;
  end
  initial begin
    cyc(5000);
    fails++;
    wrap_up;
  end
endmodule : tb
